// *** rss_consts.svh ***
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define RSS_IDX_MODE 10'h001
`define RSS_IDX_RECAL 10'h03B
`define RSS_IDX_TEMP 10'h03C
`define RSS_IDX_SUPPLY 10'h03D
`define RSS_IDX_FLAGS1 10'h03E
`define RSS_IDX_IRQ_STAT 10'h040
`define RSS_IDX_IRQ_CLR 10'h041
`define RSS_IDX_IRQ_EN 10'h042
`define RSS_IDX_SIG_LIMIT 10'h043

// ****************************************
// field positions
// ****************************************
`define RSS_MODE_F 2:0
`define RSS_RECAL_AUTO 7
`define RSS_RECAL_TRIG 6
`define RSS_RECAL_WATCH_OFF 0
`define RSS_RECAL_LIM 2:1
`define RSS_SUP_EN 3
`define RSS_SUP_TRIM 2:0
`define RSS_FLAG_SIG 3
`define RSS_BYTE_F 7:0
`define RSS_IRQ_F 5:0

// ****************************************
// reset values
// ****************************************
`define RSS_DRIFT_LIM_RST 2'h1
`define RSS_SUP_TRIM_RST 3'h2
`define RSS_SIG_LIMIT_RST 8'hFF

// ****************************************
// drift limits in degrees, codes 00 to 11
// ****************************************
`define RSS_DRIFT_DEG0 8'h05
`define RSS_DRIFT_DEG1 8'h0A
`define RSS_DRIFT_DEG2 8'h0F
`define RSS_DRIFT_DEG3 8'h14

`endif

// *** rss_pkg.sv ***
`default_nettype none
package rss_pkg;

   // ****************************************
   // operating modes
   // ****************************************
   typedef enum logic [2:0] {
      MODE_SLEEP = 3'b000,
      MODE_STANDBY = 3'b001,
      MODE_SYNTH = 3'b010,
      MODE_TX = 3'b011,
      MODE_RX = 3'b101
   } rss_mode_e;

   // ****************************************
   // radio front end status, asynchronous
   // ****************************************
   typedef struct packed {
      logic xtalRunning;
      logic synthLockRaw;
      logic sampleStarted;
      logic gainLoopsDone;
      logic paRampDone;
      logic recalDone;
      logic [7:0] thermalCode;
      logic [7:0] signalLevelReading;
   } rss_radio_s;

   // ****************************************
   // controls toward the radio
   // ****************************************
   typedef struct packed {
      rss_mode_e opMode;
      logic recalStart;
      logic autoRecalEnable;
      logic thermalWatchRun;
      logic supplyMonitorEnable;
      logic [2:0] supplyThresholdSelect;
   } rss_ctrl_s;

   typedef logic [5:0] rss_irq_t;

endpackage
`default_nettype wire

// *** rss_regs.sv ***
//
// Contract
// - bit 7 of recalibration_control enables recalibration on drift.
// - writing one to bit 6 in standby starts calibration; nothing is kept.
// - bit 5 reads one while calibration runs and zero once it is done.
// - bit 3 flags drift above the limit since the last calibration.
// - bits 2-1 pick a 5, 10, 15 or 20 degree limit, reset code 01.
// - bit 0 at zero watches temperature outside sleep and standby.
// - temperature_reading reports the sensor at minus one degree per LSB.
// - supply_monitor_control bit 3 enables the supply detector, reset 0.
// - bits 2-0 select one of eight supply thresholds, reset code 010.
// - op_state_settled sets when the requested mode is reached.
// - op_state_settled clears on a mode change until the new mode is ready.
// - receive_settled sets after gain and frequency loops, clears off rx.
// - transmit_settled sets after the amplifier ramp, clears off tx.
// - synth_locked follows lock in synth, receive or transmit mode.
// - the signal level flag sets in rx when the level beats the limit.
// - the signal level flag clears off rx or on a written one only.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.svh"

module rss_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio front end
   input wire rss_pkg::rss_radio_s radioIn,
   output var rss_pkg::rss_ctrl_s radioCtrl,
   // interrupt
   output logic irq
);
   import rss_pkg::*;

   // ****************************************
   // state
   // ****************************************
   rss_radio_s radioMeta_ff;
   rss_radio_s radioSync_ff;
   logic recalDoneDly_ff;
   rss_mode_e mode_ff;
   logic autoRecal_ff;
   logic [1:0] driftLimit_ff;
   logic watchOff_ff;
   logic recalActive_ff;
   logic driftFlag_ff;
   logic [7:0] thermal_ff;
   logic [7:0] thermalRef_ff;
   logic supplyEn_ff;
   logic [2:0] supplyTrim_ff;
   logic modeSettled_ff;
   logic rxSettled_ff;
   logic txSettled_ff;
   logic synthLocked_ff;
   logic sigLevel_ff;
   logic [7:0] sigLimit_ff;
   rss_irq_t irqStat_ff;
   rss_irq_t irqEn_ff;
   logic irq_ff;
   rss_ctrl_s ctrl_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // ****************************************
   // apb decode
   // ****************************************
   wire logic setupPhase = psel & ~penable;
   wire logic [9:0] regIdx = paddr[11:2];
   wire logic aligned = paddr[1:0] == 2'h0;
   wire logic hitMode = aligned & (regIdx == `RSS_IDX_MODE);
   wire logic hitRecal = aligned & (regIdx == `RSS_IDX_RECAL);
   wire logic hitTemp = aligned & (regIdx == `RSS_IDX_TEMP);
   wire logic hitSupply = aligned & (regIdx == `RSS_IDX_SUPPLY);
   wire logic hitFlags = aligned & (regIdx == `RSS_IDX_FLAGS1);
   wire logic hitIrqStat = aligned & (regIdx == `RSS_IDX_IRQ_STAT);
   wire logic hitIrqClr = aligned & (regIdx == `RSS_IDX_IRQ_CLR);
   wire logic hitIrqEn = aligned & (regIdx == `RSS_IDX_IRQ_EN);
   wire logic hitSigLim = aligned & (regIdx == `RSS_IDX_SIG_LIMIT);
   wire logic mapped = hitMode | hitRecal | hitTemp | hitSupply | hitFlags
      | hitIrqStat | hitIrqClr | hitIrqEn | hitSigLim;
   // writes land only on the completing access edge
   wire logic wrEn = psel & penable & pready_ff & pwrite;
   wire logic wrMode = wrEn & hitMode;
   wire logic wrRecal = wrEn & hitRecal;
   wire logic wrSupply = wrEn & hitSupply;
   wire logic wrFlags = wrEn & hitFlags;
   wire logic wrIrqClr = wrEn & hitIrqClr;
   wire logic wrIrqEn = wrEn & hitIrqEn;
   wire logic wrSigLim = wrEn & hitSigLim;
   wire logic wrSupplyEn = pwdata[`RSS_SUP_EN];

   // ****************************************
   // mode request
   // ****************************************
   wire logic [2:0] reqMode = pwdata[`RSS_MODE_F];
   // unknown codes are dropped so the mode stays legal
   wire logic modeLegal = (reqMode == MODE_SLEEP)
      | (reqMode == MODE_STANDBY) | (reqMode == MODE_SYNTH)
      | (reqMode == MODE_TX) | (reqMode == MODE_RX);
   wire logic modeChange = wrMode & modeLegal & (reqMode != mode_ff);
   wire rss_mode_e nxt_mode = modeChange ? rss_mode_e'(reqMode) : mode_ff;
   wire logic inRx = mode_ff == MODE_RX;
   wire logic inTx = mode_ff == MODE_TX;
   wire logic inSynthish = (mode_ff == MODE_SYNTH) | inRx | inTx;
   wire logic lockSync = radioSync_ff.synthLockRaw;
   wire logic lockQual = inSynthish & lockSync;

   // ****************************************
   // settled flags
   // ****************************************
   logic modeReadyNow;
   always_comb begin
      unique case (mode_ff)
         MODE_SLEEP: modeReadyNow = 1'b1;
         MODE_STANDBY: modeReadyNow = radioSync_ff.xtalRunning;
         MODE_SYNTH: modeReadyNow = lockSync;
         MODE_RX: modeReadyNow = radioSync_ff.sampleStarted;
         MODE_TX: modeReadyNow = radioSync_ff.paRampDone;
         default: modeReadyNow = 1'b0;
      endcase
   end
   // the change clears first: readiness seen now belongs to the old mode
   wire logic nxt_modeSettled = ~modeChange
      & (modeSettled_ff | modeReadyNow);
   wire logic nxt_rxSettled = inRx & ~modeChange
      & (rxSettled_ff | radioSync_ff.gainLoopsDone);
   wire logic nxt_txSettled = inTx & ~modeChange
      & (txSettled_ff | radioSync_ff.paRampDone);
   wire logic nxt_synthLocked = lockQual;
   wire logic sigAbove = inRx
      & (radioSync_ff.signalLevelReading > sigLimit_ff);
   wire logic sigClr = wrFlags & pwdata[`RSS_FLAG_SIG];
   // a new crossing beats a software clear in the same cycle
   wire logic nxt_sigLevel = inRx & ~modeChange
      & (sigAbove | (sigLevel_ff & ~sigClr));

   // ****************************************
   // temperature watch and recalibration
   // ****************************************
   wire logic watchActive = ~watchOff_ff & (mode_ff != MODE_SLEEP)
      & (mode_ff != MODE_STANDBY);
   wire logic [7:0] thermalDelta = (thermal_ff >= thermalRef_ff)
      ? thermal_ff - thermalRef_ff : thermalRef_ff - thermal_ff;
   wire logic [7:0] limitDeg = (driftLimit_ff == 2'h0) ? `RSS_DRIFT_DEG0
      : (driftLimit_ff == 2'h1) ? `RSS_DRIFT_DEG1
      : (driftLimit_ff == 2'h2) ? `RSS_DRIFT_DEG2 : `RSS_DRIFT_DEG3;
   wire logic driftDetected = watchActive & ~recalActive_ff
      & (thermalDelta > limitDeg);
   wire logic trigReq = wrRecal & pwdata[`RSS_RECAL_TRIG]
      & (mode_ff == MODE_STANDBY) & ~recalActive_ff;
   wire logic autoReq = autoRecal_ff & driftFlag_ff
      & ~recalActive_ff;
   wire logic startRecal = trigReq | autoReq;
   // edge taken from the second stage only, never the first
   wire logic recalDoneEdge = radioSync_ff.recalDone & ~recalDoneDly_ff;
   wire logic recalFinish = recalDoneEdge & recalActive_ff;
   wire logic nxt_recalActive = startRecal
      | (recalActive_ff & ~recalDoneEdge);
   wire logic nxt_driftFlag = ~startRecal
      & (driftFlag_ff | driftDetected);
   // sensor code is passed as is: one lsb is minus one degree
   wire logic [7:0] nxt_thermal = watchActive
      ? radioSync_ff.thermalCode : thermal_ff;
   wire logic [7:0] nxt_thermalRef = recalFinish
      ? thermal_ff : thermalRef_ff;

   // ****************************************
   // interrupt status
   // ****************************************
   wire rss_irq_t irqEvt = {recalFinish,
      nxt_driftFlag & ~driftFlag_ff,
      nxt_sigLevel & ~sigLevel_ff,
      nxt_txSettled & ~txSettled_ff,
      nxt_rxSettled & ~rxSettled_ff,
      nxt_modeSettled & ~modeSettled_ff};
   wire rss_irq_t irqClrMask = wrIrqClr ? pwdata[`RSS_IRQ_F] : 6'h00;
   // set wins over the write-one clear
   wire rss_irq_t nxt_irqStat = (irqStat_ff & ~irqClrMask) | irqEvt;
   wire rss_irq_t nxt_irqEn = wrIrqEn ? pwdata[`RSS_IRQ_F] : irqEn_ff;
   wire logic nxt_irq = |(nxt_irqStat & nxt_irqEn);

   // ****************************************
   // read mux
   // ****************************************
   wire logic [31:0] recalWord = {24'h000000, autoRecal_ff, 1'b0,
      recalActive_ff, 1'b0, driftFlag_ff, driftLimit_ff, watchOff_ff};
   wire logic [31:0] supplyWord = {28'h0000000, supplyEn_ff,
      supplyTrim_ff};
   wire logic [31:0] flagsWord = {24'h000000, modeSettled_ff,
      rxSettled_ff, txSettled_ff, synthLocked_ff, sigLevel_ff, 3'h0};
   wire logic [31:0] rdWord = hitMode ? {29'h00000000, mode_ff}
      : hitRecal ? recalWord
      : hitTemp ? {24'h000000, thermal_ff}
      : hitSupply ? supplyWord
      : hitFlags ? flagsWord
      : hitIrqStat ? {26'h0000000, irqStat_ff}
      : hitIrqEn ? {26'h0000000, irqEn_ff}
      : hitSigLim ? {24'h000000, sigLimit_ff} : 32'h00000000;
   // read data is sampled in the setup cycle, one cycle before completion
   wire logic [31:0] nxt_prdata = (setupPhase & ~pwrite)
      ? rdWord : 32'h00000000;

   wire rss_ctrl_s nxt_ctrl = '{opMode: nxt_mode,
      recalStart: startRecal,
      autoRecalEnable: autoRecal_ff,
      thermalWatchRun: watchActive,
      supplyMonitorEnable: supplyEn_ff,
      supplyThresholdSelect: supplyTrim_ff};

   // ****************************************
   // flops
   // ****************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         radioMeta_ff <= '0;
         radioSync_ff <= '0;
         recalDoneDly_ff <= 1'b0;
      end else begin
         radioMeta_ff <= radioIn;
         radioSync_ff <= radioMeta_ff;
         recalDoneDly_ff <= radioSync_ff.recalDone;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= MODE_STANDBY;
         autoRecal_ff <= 1'b0;
         driftLimit_ff <= `RSS_DRIFT_LIM_RST;
         watchOff_ff <= 1'b0;
         supplyEn_ff <= 1'b0;
         supplyTrim_ff <= `RSS_SUP_TRIM_RST;
         sigLimit_ff <= `RSS_SIG_LIMIT_RST;
         irqEn_ff <= 6'h00;
      end else begin
         mode_ff <= nxt_mode;
         irqEn_ff <= nxt_irqEn;
         if (wrRecal) begin
            autoRecal_ff <= pwdata[`RSS_RECAL_AUTO];
            driftLimit_ff <= pwdata[`RSS_RECAL_LIM];
            watchOff_ff <= pwdata[`RSS_RECAL_WATCH_OFF];
         end
         if (wrSupply) begin
            supplyEn_ff <= wrSupplyEn;
            supplyTrim_ff <= pwdata[`RSS_SUP_TRIM];
         end
         if (wrSigLim) begin
            sigLimit_ff <= pwdata[`RSS_BYTE_F];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         recalActive_ff <= 1'b0;
         driftFlag_ff <= 1'b0;
         thermal_ff <= 8'h00;
         thermalRef_ff <= 8'h00;
         modeSettled_ff <= 1'b0;
         rxSettled_ff <= 1'b0;
         txSettled_ff <= 1'b0;
         synthLocked_ff <= 1'b0;
         sigLevel_ff <= 1'b0;
      end else begin
         recalActive_ff <= nxt_recalActive;
         driftFlag_ff <= nxt_driftFlag;
         thermal_ff <= nxt_thermal;
         thermalRef_ff <= nxt_thermalRef;
         modeSettled_ff <= nxt_modeSettled;
         rxSettled_ff <= nxt_rxSettled;
         txSettled_ff <= nxt_txSettled;
         synthLocked_ff <= nxt_synthLocked;
         sigLevel_ff <= nxt_sigLevel;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irqStat_ff <= 6'h00;
         irq_ff <= 1'b0;
         ctrl_ff <= '{opMode: MODE_STANDBY, supplyThresholdSelect:
            `RSS_SUP_TRIM_RST, default: 1'b0};
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         irqStat_ff <= nxt_irqStat;
         irq_ff <= nxt_irq;
         ctrl_ff <= nxt_ctrl;
         prdata_ff <= nxt_prdata;
         pready_ff <= setupPhase;
         pslverr_ff <= setupPhase & ~mapped;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign radioCtrl = ctrl_ff;
   assign irq = irq_ff;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   a_auto_recal_off: assert property (
      !autoRecal_ff && !trigReq |=> !radioCtrl.recalStart)
      else $error("recalibration started with auto off and no trigger");
   a_trig_start_busy: assert property (
      trigReq |=> radioCtrl.recalStart ##1 !radioCtrl.recalStart)
      else $error("manual trigger did not give a one-cycle start");
   a_trig_standby: assert property (
      $rose(recalActive_ff) |-> $past(mode_ff) == MODE_STANDBY
      || $past(autoRecal_ff))
      else $error("calibration started outside standby");
   a_recal_done_idle: assert property (
      recalFinish && !startRecal |=> !recalActive_ff)
      else $error("busy bit stayed up after calibration finished");
   a_drift_flagged: assert property (
      driftDetected |=> driftFlag_ff || recalActive_ff)
      else $error("drift above the limit was not flagged");
   a_watch_off_quiet: assert property (
      watchOff_ff |-> !driftDetected)
      else $error("drift detected with monitoring stopped");
   a_temp_hold: assert property (
      !watchActive |=> thermal_ff == $past(thermal_ff))
      else $error("temperature reading moved while not monitoring");
   a_supply_write: assert property (
      wrSupply |=> supplyEn_ff == $past(wrSupplyEn)
      ##1 radioCtrl.supplyMonitorEnable == supplyEn_ff)
      else $error("supply detector enable did not follow the write");
   a_sleep_settles: assert property (
      mode_ff == MODE_SLEEP && !modeChange |=> modeSettled_ff)
      else $error("sleep was not reported as settled");
   a_change_clears: assert property (
      modeChange |=> !modeSettled_ff)
      else $error("mode settled flag survived a mode change");
   a_rx_leave_clear: assert property (
      !inRx |=> !rxSettled_ff && !sigLevel_ff)
      else $error("receive flags set outside receive mode");
   a_tx_leave_clear: assert property (
      !inTx |=> !txSettled_ff)
      else $error("transmit settled set outside transmit mode");
   a_lock_follow: assert property (
      synthLocked_ff == $past(lockQual))
      else $error("lock flag does not follow the loop");
   a_level_set_wins: assert property (
      sigAbove && !modeChange |=> sigLevel_ff)
      else $error("signal level crossing was lost");

   c_recal_cycle: cover property (startRecal ##[1:200] recalFinish);
   c_mode_settle: cover property (modeChange ##[2:50] modeSettled_ff);
   c_level_clear: cover property (sigLevel_ff ##1 sigClr ##1 !sigLevel_ff);
   c_irq_raise: cover property ($rose(irq_ff));

endmodule

`default_nettype wire

// *** rss_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.svh"

module rss_regs_tb_top;
   import rss_pkg::*;

   // ****************************************
   // stimulus and design
   // ****************************************
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   rss_radio_s radioIn = '0;
   rss_ctrl_s radioCtrl;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;

   rss_regs uut (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .radioIn(radioIn),
      .radioCtrl(radioCtrl),
      .irq(irq)
   );

   always #20 sys_clk = ~sys_clk;

   // whole run needs well under 2000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic complete_run;
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // flop outputs are read in the active region, before this edge's updates
   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      rd = 32'h0;
      err = 1'b0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no wait limit here: only the bench timeout ends a hung transfer
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb(1'b1, idx, wd, d, e);
   endtask

   task automatic rdchk(input string what, input logic [9:0] idx,
                        input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
      chk(what, exp, d);
      chk({what, " err"}, 32'h0, {31'h0, e});
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic reset_values;
      logic [31:0] d;
      logic e;
      rdchk("mode", `RSS_IDX_MODE, 32'h01);
      rdchk("recal", `RSS_IDX_RECAL, 32'h02);
      rdchk("temp", `RSS_IDX_TEMP, 32'h00);
      rdchk("supply", `RSS_IDX_SUPPLY, 32'h02);
      rdchk("flags", `RSS_IDX_FLAGS1, 32'h00);
      rdchk("irq en", `RSS_IDX_IRQ_EN, 32'h00);
      rdchk("sig limit", `RSS_IDX_SIG_LIMIT, 32'hFF);
      apb(1'b0, 10'h3FF, 32'h0, d, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
      chk("ctrl trim", 32'h2, radioCtrl.supplyThresholdSelect);
   endtask

   task automatic control_fields;
      for (int c = 0; c < 4; c++) begin
         wr(`RSS_IDX_RECAL, {29'h0, c[1:0], 1'b1});
         rdchk("limit", `RSS_IDX_RECAL, {29'h0, c[1:0], 1'b1});
      end
      chk("watch run", 32'h0, radioCtrl.thermalWatchRun);
      wr(`RSS_IDX_RECAL, 32'h81);
      rdchk("auto", `RSS_IDX_RECAL, 32'h81);
      chk("auto ctrl", 32'h1, radioCtrl.autoRecalEnable);
      wr(`RSS_IDX_RECAL, 32'h01);
      // control word follows the register one edge later
      ticks(2);
      chk("auto off", 32'h0, radioCtrl.autoRecalEnable);
      for (int c = 0; c < 8; c++) begin
         wr(`RSS_IDX_SUPPLY, {24'h0, 5'h1F, c[2:0]});
         rdchk("supply", `RSS_IDX_SUPPLY, {28'h0, 1'b1, c[2:0]});
         chk("trim ctrl", c, radioCtrl.supplyThresholdSelect);
         chk("bat en", 32'h1, radioCtrl.supplyMonitorEnable);
      end
      wr(`RSS_IDX_TEMP, 32'h55);
      rdchk("temp ro", `RSS_IDX_TEMP, 32'h00);
   endtask

   task automatic calibration;
      wr(`RSS_IDX_MODE, 32'h2);
      wr(`RSS_IDX_RECAL, 32'h41);
      rdchk("trig off standby", `RSS_IDX_RECAL, 32'h01);
      wr(`RSS_IDX_MODE, 32'h1);
      wr(`RSS_IDX_RECAL, 32'h41);
      ticks(1);
      chk("start pulse", 32'h1, radioCtrl.recalStart);
      ticks(1);
      chk("start end", 32'h0, radioCtrl.recalStart);
      rdchk("busy", `RSS_IDX_RECAL, 32'h21);
      radioIn.recalDone <= 1'b1;
      ticks(4);
      rdchk("done", `RSS_IDX_RECAL, 32'h01);
      rdchk("stat cal", `RSS_IDX_IRQ_STAT, 32'h20);
      chk("irq masked", 32'h0, irq);
      wr(`RSS_IDX_IRQ_EN, 32'h20);
      ticks(2);
      chk("irq on", 32'h1, irq);
      wr(`RSS_IDX_IRQ_CLR, 32'h20);
      ticks(2);
      chk("irq cleared", 32'h0, irq);
      rdchk("stat clr", `RSS_IDX_IRQ_STAT, 32'h00);
      rdchk("clr reads", `RSS_IDX_IRQ_CLR, 32'h00);
      radioIn.recalDone <= 1'b0;
   endtask

   task automatic mode_flags;
      radioIn.xtalRunning <= 1'b1;
      ticks(4);
      rdchk("standby ready", `RSS_IDX_FLAGS1, 32'h80);
      wr(`RSS_IDX_MODE, 32'h4);
      rdchk("bad mode", `RSS_IDX_MODE, 32'h01);
      wr(`RSS_IDX_MODE, 32'h5);
      rdchk("rx entry", `RSS_IDX_FLAGS1, 32'h00);
      chk("op mode", 32'h5, radioCtrl.opMode);
      radioIn.sampleStarted <= 1'b1;
      ticks(4);
      rdchk("rx mode", `RSS_IDX_FLAGS1, 32'h80);
      radioIn.gainLoopsDone <= 1'b1;
      radioIn.synthLockRaw <= 1'b1;
      ticks(4);
      rdchk("rx ready", `RSS_IDX_FLAGS1, 32'hD0);
      wr(`RSS_IDX_SIG_LIMIT, 32'h40);
      radioIn.signalLevelReading <= 8'h41;
      ticks(4);
      rdchk("sig over", `RSS_IDX_FLAGS1, 32'hD8);
      radioIn.signalLevelReading <= 8'h40;
      ticks(4);
      wr(`RSS_IDX_FLAGS1, 32'h00);
      rdchk("sig w0", `RSS_IDX_FLAGS1, 32'hD8);
      wr(`RSS_IDX_FLAGS1, 32'h08);
      rdchk("sig w1", `RSS_IDX_FLAGS1, 32'hD0);
      radioIn.signalLevelReading <= 8'h90;
      ticks(4);
      rdchk("sig again", `RSS_IDX_FLAGS1, 32'hD8);
      wr(`RSS_IDX_MODE, 32'h3);
      rdchk("leave rx", `RSS_IDX_FLAGS1, 32'h10);
      radioIn.paRampDone <= 1'b1;
      ticks(4);
      rdchk("tx ready", `RSS_IDX_FLAGS1, 32'hB0);
      radioIn.synthLockRaw <= 1'b0;
      ticks(4);
      rdchk("unlock", `RSS_IDX_FLAGS1, 32'hA0);
      wr(`RSS_IDX_MODE, 32'h1);
      ticks(4);
      rdchk("leave tx", `RSS_IDX_FLAGS1, 32'h80);
      wr(`RSS_IDX_MODE, 32'h0);
      rdchk("sleep ready", `RSS_IDX_FLAGS1, 32'h80);
      wr(`RSS_IDX_MODE, 32'h1);
      rdchk("stat events", `RSS_IDX_IRQ_STAT, 32'h0F);
      wr(`RSS_IDX_IRQ_CLR, 32'h3F);
      radioIn.paRampDone <= 1'b0;
      radioIn.gainLoopsDone <= 1'b0;
      radioIn.sampleStarted <= 1'b0;
   endtask

   // reference temperature is 0 from the finished calibration
   task automatic drift;
      wr(`RSS_IDX_RECAL, 32'h00);
      wr(`RSS_IDX_MODE, 32'h2);
      radioIn.thermalCode <= 8'h05;
      ticks(5);
      rdchk("temp 5", `RSS_IDX_TEMP, 32'h05);
      chk("watch on", 32'h1, radioCtrl.thermalWatchRun);
      rdchk("no drift", `RSS_IDX_RECAL, 32'h00);
      radioIn.thermalCode <= 8'h06;
      ticks(5);
      rdchk("drift", `RSS_IDX_RECAL, 32'h08);
      rdchk("stat drift", `RSS_IDX_IRQ_STAT, 32'h10);
      wr(`RSS_IDX_RECAL, 32'h01);
      radioIn.thermalCode <= 8'h30;
      ticks(5);
      rdchk("watch off", `RSS_IDX_TEMP, 32'h06);
      // standby first, so the stale sensor code is never copied
      wr(`RSS_IDX_MODE, 32'h1);
      wr(`RSS_IDX_RECAL, 32'h00);
      ticks(5);
      rdchk("standby hold", `RSS_IDX_TEMP, 32'h06);
      wr(`RSS_IDX_RECAL, 32'h80);
      rdchk("auto start", `RSS_IDX_RECAL, 32'hA0);
      radioIn.recalDone <= 1'b1;
      ticks(4);
      rdchk("auto done", `RSS_IDX_RECAL, 32'h80);
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      reset_values();
      control_fields();
      calibration();
      mode_flags();
      drift();
      complete_run();
   end
endmodule
`default_nettype wire
